// ===== touch_detect_sequencer.sv
// Touch-detect and panel-settling sequencer with APB registers
`timescale 1ns/1ps
module touch_detect_sequencer (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Panel comparator and scan engine
    input wire logic touch_sense_i,
    input wire logic scan_done_i,
    output logic scan_start_o,
    // Panel switches
    output logic pullup_switch_o,
    output logic pullup_value_select_o,
    output logic x_plus_drive_switch_o,
    output logic y_minus_ground_switch_o,
    output logic y_plus_drive_switch_o,
    output logic [1:0] x_plus_node_o,
    output logic [1:0] x_minus_node_o,
    output logic [1:0] y_plus_node_o,
    output logic [1:0] y_minus_node_o,
    // Interrupt
    output logic touch_interrupt_out_o
);
    // Local widths
    localparam int IRQ_W_LOCAL = touch_detect_pkg::IRQ_W;
    localparam int PRE_W_BITS = touch_detect_pkg::PRE_W;

    // Registers
    logic [2:0] ctrl_ff;
    logic [15:0] timing_ff;
    logic [1:0] meas_ff;
    logic [IRQ_W_LOCAL-1:0] irq_stat_ff;
    logic [IRQ_W_LOCAL-1:0] irq_mask_ff;
    logic [1:0] tag_meas_ff;
    logic tag_touch_ff;
    logic data_valid_ff;
    logic scan_cmd_ff;

    // Synchronisers
    logic touch_s1_ff;
    logic touch_s2_ff;
    logic done_s1_ff;
    logic done_s2_ff;

    // Sequencer
    touch_detect_pkg::seq_state_t state_ff;
    touch_detect_pkg::seq_state_t nxt_state;
    logic [touch_detect_pkg::PRE_W-1:0] pre_ff;
    logic [touch_detect_pkg::TIM_W-1:0] cnt_ff;
    logic tick;
    logic apb_wr;
    logic apb_rd;
    logic autonomous_conversion_mode;
    logic low_power_state;
    logic [touch_detect_pkg::TIM_W-1:0] fast_len;
    logic [touch_detect_pkg::TIM_W-1:0] fine_len;
    logic cnt_zero;
    logic touch_ev;
    logic done_ev;
    logic irq_rd;
    logic [IRQ_W_LOCAL-1:0] irq_set;

    assign apb_wr = psel_i && penable_i && pwrite_i;
    assign apb_rd = psel_i && penable_i && !pwrite_i;
    // Zero wait: read data is a flop already latched in the setup cycle
    assign pready_o = 1'b1;
    assign autonomous_conversion_mode = ctrl_ff[touch_detect_pkg::CTRL_ACM_BIT];
    assign low_power_state = ctrl_ff[touch_detect_pkg::CTRL_LPM_BIT];
    assign fast_len = timing_ff[touch_detect_pkg::TIM_FAST_LSB +: touch_detect_pkg::TIM_W];
    assign fine_len = timing_ff[touch_detect_pkg::TIM_FINE_LSB +: touch_detect_pkg::TIM_W];
    assign cnt_zero = (cnt_ff == '0);
    assign irq_rd = apb_rd && (paddr_i == touch_detect_pkg::ADDR_IRQ_STAT);

    // Two-flop synchronisers for panel-side inputs
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            touch_s1_ff <= 1'b0;
            touch_s2_ff <= 1'b0;
            done_s1_ff <= 1'b0;
            done_s2_ff <= 1'b0;
        end else begin
            touch_s1_ff <= touch_sense_i;
            touch_s2_ff <= touch_s1_ff;
            done_s1_ff <= scan_done_i;
            done_s2_ff <= done_s1_ff;
        end
    end

    // high comparator output is a touch
    assign touch_ev = (state_ff == touch_detect_pkg::ST_DETECT) && touch_s2_ff;
    // done only once status resolved and data tagged
    assign done_ev = (state_ff == touch_detect_pkg::ST_RESOLVE);

    // Register writes
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_ff <= touch_detect_pkg::CTRL_RESET;
            timing_ff <= touch_detect_pkg::TIMING_RESET;
            irq_mask_ff <= '0;
            meas_ff <= touch_detect_pkg::MEAS_X;
        end else if (apb_wr) begin
            case (paddr_i)
                // pullup value select lives in control
                touch_detect_pkg::ADDR_CTRL: ctrl_ff <= pwdata_i[2:0];
                touch_detect_pkg::ADDR_TIMING: timing_ff <= pwdata_i[15:0];
                touch_detect_pkg::ADDR_IRQ_MASK: irq_mask_ff <= pwdata_i[IRQ_W_LOCAL-1:0];
                touch_detect_pkg::ADDR_SCAN: meas_ff <= pwdata_i[1:0];
                default: ctrl_ff <= ctrl_ff;
            endcase
        end
    end

    // Direct-mode scan command, one pulse per write
    // Dropped unless in detect; software checks status before asking
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scan_cmd_ff <= 1'b0;
        end else begin
            scan_cmd_ff <= apb_wr && (paddr_i == touch_detect_pkg::ADDR_SCAN) && !autonomous_conversion_mode;
        end
    end

    // Sticky interrupt status; set beats read-clear
    // direct mode flags touch as interrupt
    assign irq_set[touch_detect_pkg::IRQ_TOUCH_BIT] = touch_ev && !autonomous_conversion_mode;
    assign irq_set[touch_detect_pkg::IRQ_DONE_BIT] = done_ev;
    // Only bits returned by the read are cleared, so a late set is never lost
    for (genvar b = 0; b < IRQ_W_LOCAL; b++) begin : g_irq
        always_ff @(posedge ref_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                irq_stat_ff[b] <= 1'b0;
            end else if (irq_set[b]) begin
                irq_stat_ff[b] <= 1'b1;
            end else if (irq_rd && prdata_o[b]) begin
                irq_stat_ff[b] <= 1'b0;
            end
        end
    end
    assign touch_interrupt_out_o = |(irq_stat_ff & irq_mask_ff);

    // Read data mux registered in the setup cycle
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
                touch_detect_pkg::ADDR_CTRL: prdata_o <= {29'h0, ctrl_ff};
                touch_detect_pkg::ADDR_TIMING: prdata_o <= {16'h0, timing_ff};
                touch_detect_pkg::ADDR_STATUS:
                    prdata_o <= {24'h0, data_valid_ff, tag_touch_ff, tag_meas_ff,
                                 touch_s2_ff, state_ff};
                touch_detect_pkg::ADDR_IRQ_STAT: prdata_o <= {30'h0, irq_stat_ff};
                touch_detect_pkg::ADDR_IRQ_MASK: prdata_o <= {30'h0, irq_mask_ff};
                touch_detect_pkg::ADDR_SCAN: prdata_o <= {30'h0, meas_ff};
                default: prdata_o <= 32'h0000_0000;
            endcase
        end
    end
    // Only beyond the map is refused; holes inside it read as zero
    assign pslverr_o = psel_i && penable_i && (paddr_i > touch_detect_pkg::ADDR_SCAN);

    // Next-state logic
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            touch_detect_pkg::ST_LOW_POWER: begin
                if (!low_power_state) begin
                    nxt_state = touch_detect_pkg::ST_DETECT;
                end
            end
            touch_detect_pkg::ST_DETECT: begin
                if (low_power_state) begin
                    nxt_state = touch_detect_pkg::ST_LOW_POWER;
                // autonomous mode starts its own scan
                end else if ((touch_ev && autonomous_conversion_mode) || scan_cmd_ff) begin
                    nxt_state = touch_detect_pkg::ST_SCAN;
                end
            end
            touch_detect_pkg::ST_SCAN: begin
                // on to fast settling after scan; zero fast length skips it
                if (done_s2_ff) begin
                    nxt_state = (fast_len == '0) ? touch_detect_pkg::ST_FINE
                                                 : touch_detect_pkg::ST_FAST;
                end
            end
            touch_detect_pkg::ST_FAST: begin
                if (tick && cnt_zero) begin
                    nxt_state = touch_detect_pkg::ST_FINE;
                end
            end
            touch_detect_pkg::ST_FINE: begin
                if (tick && cnt_zero) begin
                    nxt_state = touch_detect_pkg::ST_RESOLVE;
                end
            end
            touch_detect_pkg::ST_RESOLVE: begin
                // tag then go to mode-dependent idle
                nxt_state = low_power_state ? touch_detect_pkg::ST_LOW_POWER : touch_detect_pkg::ST_DETECT;
            end
            default: nxt_state = touch_detect_pkg::ST_LOW_POWER;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff <= touch_detect_pkg::ST_LOW_POWER;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // prescaler runs only in timed states, idle is untimed
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pre_ff <= '0;
        end else if (state_ff != touch_detect_pkg::ST_FAST
                     && state_ff != touch_detect_pkg::ST_FINE) begin
            pre_ff <= '0;
        end else if (pre_ff == PRE_W_BITS'(touch_detect_pkg::TICK_CYC - 1)) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + 1'b1;
        end
    end
    assign tick = (pre_ff == PRE_W_BITS'(touch_detect_pkg::TICK_CYC - 1));

    // one counter, fast length then fine length
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_ff <= '0;
        end else if (state_ff == touch_detect_pkg::ST_SCAN) begin
            cnt_ff <= (fast_len == '0) ? fine_len : fast_len - 1'b1;
        end else if (state_ff == touch_detect_pkg::ST_FAST && tick && cnt_zero) begin
            cnt_ff <= fine_len;
        end else if (tick && !cnt_zero) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    // tag measurement with resolved touch status
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tag_meas_ff <= touch_detect_pkg::MEAS_X;
            tag_touch_ff <= 1'b0;
            data_valid_ff <= 1'b0;
        end else if (state_ff == touch_detect_pkg::ST_SCAN) begin
            data_valid_ff <= 1'b0;
        end else if (done_ev) begin
            tag_meas_ff <= meas_ff;
            tag_touch_ff <= touch_s2_ff;
            data_valid_ff <= 1'b1;
        end
    end

    assign scan_start_o = (state_ff != touch_detect_pkg::ST_SCAN)
                          && (nxt_state == touch_detect_pkg::ST_SCAN);

    // Panel switch decode; no host setup needed
    always_comb begin
        pullup_switch_o = 1'b0;
        x_plus_drive_switch_o = 1'b0;
        y_minus_ground_switch_o = 1'b0;
        y_plus_drive_switch_o = 1'b0;
        x_plus_node_o = touch_detect_pkg::NODE_OPEN;
        x_minus_node_o = touch_detect_pkg::NODE_OPEN;
        y_plus_node_o = touch_detect_pkg::NODE_OPEN;
        y_minus_node_o = touch_detect_pkg::NODE_OPEN;
        case (state_ff)
            // pullup in detect, fine and resolve; detect setup, low power leaves all open
            touch_detect_pkg::ST_DETECT, touch_detect_pkg::ST_FINE,
            touch_detect_pkg::ST_RESOLVE: begin
                pullup_switch_o = 1'b1;
                y_minus_ground_switch_o = 1'b1;
                y_minus_node_o = touch_detect_pkg::NODE_GROUND;
            end
            // X+ drive in parallel with pullup
            touch_detect_pkg::ST_FAST: begin
                pullup_switch_o = 1'b1;
                x_plus_drive_switch_o = 1'b1;
                y_minus_ground_switch_o = 1'b1;
                x_plus_node_o = touch_detect_pkg::NODE_SUPPLY;
                y_minus_node_o = touch_detect_pkg::NODE_GROUND;
            end
            touch_detect_pkg::ST_SCAN: begin
                case (meas_ff)
                    touch_detect_pkg::MEAS_X: begin
                        x_plus_node_o = touch_detect_pkg::NODE_SUPPLY;
                        x_minus_node_o = touch_detect_pkg::NODE_GROUND;
                        y_plus_node_o = touch_detect_pkg::NODE_ADC;
                        x_plus_drive_switch_o = 1'b1;
                    end
                    touch_detect_pkg::MEAS_Y: begin
                        y_plus_node_o = touch_detect_pkg::NODE_SUPPLY;
                        y_minus_node_o = touch_detect_pkg::NODE_GROUND;
                        x_plus_node_o = touch_detect_pkg::NODE_ADC;
                        y_plus_drive_switch_o = 1'b1;
                        y_minus_ground_switch_o = 1'b1;
                    end
                    touch_detect_pkg::MEAS_Z1: begin
                        y_plus_node_o = touch_detect_pkg::NODE_SUPPLY;
                        x_minus_node_o = touch_detect_pkg::NODE_GROUND;
                        x_plus_node_o = touch_detect_pkg::NODE_ADC;
                        y_plus_drive_switch_o = 1'b1;
                    end
                    default: begin
                        y_plus_node_o = touch_detect_pkg::NODE_SUPPLY;
                        x_minus_node_o = touch_detect_pkg::NODE_GROUND;
                        y_minus_node_o = touch_detect_pkg::NODE_ADC;
                        y_plus_drive_switch_o = 1'b1;
                    end
                endcase
            end
            default: pullup_switch_o = 1'b0;
        endcase
    end
    // resistance choice drives the select pin
    assign pullup_value_select_o = ctrl_ff[touch_detect_pkg::CTRL_RSEL_BIT];
endmodule : touch_detect_sequencer

// ===== touch_detect_pkg.sv
// Package of constants and types for the touch-detect sequencer
package touch_detect_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TIMING = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ADDR_SCAN = 8'h14;
    // Control register fields
    localparam int CTRL_ACM_BIT = 0;
    localparam int CTRL_RSEL_BIT = 1;
    localparam int CTRL_LPM_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    // Timing register fields: fast length low byte, fine length high byte
    localparam int TIM_W = 8;
    localparam int TIM_FAST_LSB = 0;
    localparam int TIM_FINE_LSB = 8;
    localparam logic [15:0] TIMING_RESET = 16'h1000;
    // Interrupt status bits
    localparam int IRQ_TOUCH_BIT = 0;
    localparam int IRQ_DONE_BIT = 1;
    localparam int IRQ_W = 2;
    // Measurement select for scan command
    localparam int MEAS_W = 2;
    localparam logic [1:0] MEAS_X = 2'h0;
    localparam logic [1:0] MEAS_Y = 2'h1;
    localparam logic [1:0] MEAS_Z1 = 2'h2;
    localparam logic [1:0] MEAS_Z2 = 2'h3;
    // Panel node connection codes
    localparam logic [1:0] NODE_OPEN = 2'h0;
    localparam logic [1:0] NODE_SUPPLY = 2'h1;
    localparam logic [1:0] NODE_GROUND = 2'h2;
    localparam logic [1:0] NODE_ADC = 2'h3;
    // Settling prescaler: one tick per microsecond
    localparam int CLK_MHZ = 25;
    localparam int TICK_NS = 1000;
    localparam int CLK_NS = 1000 / CLK_MHZ;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int PRE_W = 5;

    typedef enum logic [2:0] {
        ST_LOW_POWER = 3'b000,
        ST_DETECT = 3'b001,
        ST_SCAN = 3'b010,
        ST_FAST = 3'b011,
        ST_FINE = 3'b100,
        ST_RESOLVE = 3'b101
    } seq_state_t;
endpackage : touch_detect_pkg

// ===== touch_detect_sequencer_asserts.sv
// Port-level assertions for the touch-detect sequencer
`timescale 1ns/1ps
module touch_detect_sequencer_chk (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Panel side
    input wire logic scan_start_o,
    input wire logic pullup_switch_o,
    input wire logic pullup_value_select_o,
    input wire logic x_plus_drive_switch_o,
    input wire logic y_minus_ground_switch_o,
    input wire logic y_plus_drive_switch_o,
    input wire logic touch_interrupt_out_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    wire logic acc = psel_i && penable_i;
    wire logic sel_bit = pwdata_i[1];
    chk_apb_ready: assert property (acc |-> pready_o)
        else $error("access phase without ready");
    chk_bad_addr: assert property (acc && paddr_i > 8'h14 |-> pslverr_o && (pwrite_i || prdata_o == 32'h0))
        else $error("unmapped access not refused");
    chk_good_addr: assert property (acc && paddr_i <= 8'h14 |-> !pslverr_o)
        else $error("mapped access refused");
    chk_select_follows: assert property ( // pullup choice
        acc && pwrite_i && paddr_i == touch_detect_pkg::ADDR_CTRL |=> pullup_value_select_o == $past(sel_bit))
        else $error("pullup select not updated");
    chk_start_pulse: assert property (scan_start_o |=> !scan_start_o) // single pulse
        else $error("scan start longer than one cycle");
    chk_start_idle: assert property (scan_start_o |-> pullup_switch_o && y_minus_ground_switch_o)
        else $error("scan started outside detect");
    chk_scan_open: assert property (scan_start_o |=> !pullup_switch_o) // scan setup
        else $error("pullup left on in scan");
    chk_fast_ground: assert property ( // fast drive
        x_plus_drive_switch_o && pullup_switch_o |-> y_minus_ground_switch_o
        && !y_plus_drive_switch_o)
        else $error("fast interval setup wrong");
    chk_fast_to_fine: assert property ($fell(x_plus_drive_switch_o) |-> pullup_switch_o)
        else $error("fast interval not followed by fine");
    chk_pullup_clean: assert property (pullup_switch_o |-> !y_plus_drive_switch_o)
        else $error("Y+ drive on with pullup");
    cover property (scan_start_o);
    cover property ($rose(x_plus_drive_switch_o));
    cover property ($rose(touch_interrupt_out_o));
endmodule : touch_detect_sequencer_chk

bind touch_detect_sequencer touch_detect_sequencer_chk chk_u (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .scan_start_o(scan_start_o),
    .pullup_switch_o(pullup_switch_o), .pullup_value_select_o(pullup_value_select_o),
    .x_plus_drive_switch_o(x_plus_drive_switch_o),
    .y_minus_ground_switch_o(y_minus_ground_switch_o),
    .y_plus_drive_switch_o(y_plus_drive_switch_o), .touch_interrupt_out_o(touch_interrupt_out_o));

// ===== panel_model.sv
// Behavioural resistive panel and scan engine facing the sequencer
`timescale 1ns/1ps
module panel_model (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Bench controls
    input wire logic touched_i,
    input wire logic [7:0] scan_delay_i,
    // Sequencer side
    input wire logic scan_start_i,
    input wire logic pullup_switch_i,
    input wire logic x_plus_drive_switch_i,
    output logic touch_sense_o,
    output logic scan_done_o
);
    logic [7:0] wait_ff;
    logic [2:0] hold_ff;
    // Plates only seen through the weak pullup; strong X+ drive masks a touch
    assign touch_sense_o = touched_i && pullup_switch_i && !x_plus_drive_switch_i;
    // Done held several cycles so the two-flop sync cannot miss it
    assign scan_done_o = (hold_ff != 3'h0);
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wait_ff <= 8'h00;
            hold_ff <= 3'h0;
        end else if (scan_start_i) begin
            wait_ff <= scan_delay_i;
        end else if (wait_ff != 8'h00) begin
            wait_ff <= wait_ff - 8'h01;
            if (wait_ff == 8'h01) hold_ff <= 3'h6;
        end else if (hold_ff != 3'h0) begin
            hold_ff <= hold_ff - 3'h1;
        end
    end
endmodule : panel_model

// ===== tb_touch_detect_sequencer.sv
// Self-checking bench for the touch-detect sequencer
`timescale 1ns/1ps
module tb_touch_detect_sequencer;
    typedef struct packed {
        logic [1:0] meas;
        logic [7:0] fast;
        logic [7:0] fine;
        logic touch;
        logic [7:0] nodes;
    } row_t;
    logic ref_clk_i = 1'b0, resetn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, scan_delay = 8'h03;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic touched = 1'b0, pready, pslverr, err, sense, done, start, pu_sw, pu_sel, xp_sw;
    logic ym_sw, yp_sw, irq;
    logic [1:0] xp_n, xm_n, yp_n, ym_n;
    int failures = 0, n_compared = 0, cycles = 0, n_fast = 0, n_fine = 0;
    // Nodes as {x+, x-, y+, y-}: 0 open, 1 supply, 2 ground, 3 ADC
    row_t rows [4] = '{'{2'h0, 8'h02, 8'h01, 1'b0, 8'h6C}, '{2'h1, 8'h00, 8'h02, 1'b1, 8'hC6},
        '{2'h2, 8'h01, 8'h00, 1'b1, 8'hE4}, '{2'h3, 8'h03, 8'h03, 1'b0, 8'h27}};
    touch_detect_sequencer dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .touch_sense_i(sense),
        .scan_done_i(done), .scan_start_o(start), .pullup_switch_o(pu_sw),
        .pullup_value_select_o(pu_sel), .x_plus_drive_switch_o(xp_sw),
        .y_minus_ground_switch_o(ym_sw), .y_plus_drive_switch_o(yp_sw), .x_plus_node_o(xp_n),
        .x_minus_node_o(xm_n), .y_plus_node_o(yp_n), .y_minus_node_o(ym_n),
        .touch_interrupt_out_o(irq));
    panel_model panel_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .touched_i(touched),
        .scan_delay_i(scan_delay), .scan_start_i(start), .pullup_switch_i(pu_sw),
        .x_plus_drive_switch_i(xp_sw), .touch_sense_o(sense), .scan_done_o(done));
    always #20 ref_clk_i = ~ref_clk_i;
    // Run is well under 10k cycles; ceiling only catches a hang
    always @(posedge ref_clk_i) begin
        cycles++;
        // Fast is X+ drive beside the pullup; fine is the pullup alone
        if (xp_sw === 1'b1 && pu_sw === 1'b1) n_fast++;
        if (pu_sw === 1'b1 && xp_sw !== 1'b1) n_fine++;
        if (cycles == 40000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        @(posedge ref_clk_i);
        while (pready !== 1'b1) @(posedge ref_clk_i);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Waits for scan state (pullup open) or for the interrupt line
    task automatic wait_hi(input bit on_irq);
        int i;
        for (i = 0; i < 3000; i++) begin
            #1;
            if ((on_irq ? irq : !pu_sw) === 1'b1) break;
            @(posedge ref_clk_i);
        end
        if (i == 3000) check(32'h0, 32'h1);
    endtask : wait_hi
    function automatic logic [31:0] near(input int seen, input int want);
        return {31'h0, (seen >= want - 25) && (seen <= want + 25)};
    endfunction : near
    initial begin
        repeat (4) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        @(posedge ref_clk_i);
        #1;
        check({28'h0, pu_sw, ym_sw, xp_sw, yp_sw}, 32'hC); // idle switches
        apb(1'b0, touch_detect_pkg::ADDR_CTRL, 32'h0);
        check(rd, 32'h0); // control reset
        apb(1'b0, touch_detect_pkg::ADDR_TIMING, 32'h0);
        check(rd, 32'h1000); // timing reset
        apb(1'b0, 8'h18, 32'h0);
        check({rd[30:0], err}, 32'h1); // unmapped refused
        apb(1'b1, touch_detect_pkg::ADDR_IRQ_MASK, 32'h2);
        for (int r = 0; r < 4; r++) begin
            touched <= rows[r].touch;
            apb(1'b1, touch_detect_pkg::ADDR_TIMING, {16'h0, rows[r].fine, rows[r].fast});
            apb(1'b0, touch_detect_pkg::ADDR_TIMING, 32'h0);
            check(rd, {16'h0, rows[r].fine, rows[r].fast}); // timing readback
            apb(1'b1, touch_detect_pkg::ADDR_SCAN, {30'h0, rows[r].meas});
            wait_hi(1'b0);
            n_fast = 0;
            n_fine = 0;
            check({24'h0, xp_n, xm_n, yp_n, ym_n}, {24'h0, rows[r].nodes}); // scan nodes
            wait_hi(1'b1);
            check(rows[r].fast == 8'h00 ? {31'h0, n_fast == 0} : // fast length
                near(n_fast, rows[r].fast * touch_detect_pkg::TICK_CYC), 32'h1);
            check(near(n_fine, (rows[r].fine + 1) * touch_detect_pkg::TICK_CYC), 32'h1);
            check({28'h0, pu_sw, ym_sw, xp_sw, yp_sw}, 32'hC); // back to detect
            apb(1'b0, touch_detect_pkg::ADDR_STATUS, 32'h0);
            check({28'h0, rd[7:4]}, {28'h0, 1'b1, rows[r].touch, rows[r].meas}); // tags
            apb(1'b0, touch_detect_pkg::ADDR_IRQ_STAT, 32'h0);
            #1;
            check({30'h0, rd[1], irq}, 32'h2); // done event
        end
        apb(1'b1, touch_detect_pkg::ADDR_IRQ_MASK, 32'h1);
        touched <= 1'b1;
        wait_hi(1'b1); // direct touch
        touched <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        apb(1'b0, touch_detect_pkg::ADDR_IRQ_STAT, 32'h0);
        #1;
        check({rd[30:0], irq}, 32'h2); // touch event
        apb(1'b1, touch_detect_pkg::ADDR_IRQ_MASK, 32'h0);
        touched <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        #1;
        check({31'h0, irq}, 32'h0); // masked touch quiet
        touched <= 1'b0;
        apb(1'b0, touch_detect_pkg::ADDR_IRQ_STAT, 32'h0);
        check({31'h0, rd[0]}, 32'h1); // masked touch kept
        apb(1'b1, touch_detect_pkg::ADDR_IRQ_MASK, 32'h2);
        apb(1'b1, touch_detect_pkg::ADDR_CTRL, 32'h3);
        #1;
        check({31'h0, pu_sel}, 32'h1); // high pullup value
        scan_delay <= 8'd40;
        touched <= 1'b1;
        wait_hi(1'b0); // autonomous self start
        touched <= 1'b0;
        wait_hi(1'b1);
        apb(1'b0, touch_detect_pkg::ADDR_STATUS, 32'h0);
        check({30'h0, rd[7:6]}, 32'h2); // release tagged
        apb(1'b0, touch_detect_pkg::ADDR_IRQ_STAT, 32'h0);
        // Scan starts only from detect; low power is armed while it runs
        apb(1'b1, touch_detect_pkg::ADDR_CTRL, 32'h0);
        apb(1'b1, touch_detect_pkg::ADDR_SCAN, 32'h0);
        apb(1'b1, touch_detect_pkg::ADDR_CTRL, 32'h4);
        wait_hi(1'b1);
        @(posedge ref_clk_i);
        #1;
        check({20'h0, pu_sw, ym_sw, xp_sw, yp_sw, xp_n, xm_n, yp_n, ym_n}, 32'h0); // off
        report_and_stop();
    end
endmodule : tb_touch_detect_sequencer
